//--- pkg/radio_spi_pkg.sv
// package: register map, header layout and shared types of the radio SPI port
package radio_spi_pkg;

  localparam int unsigned REG_COUNT = 47;
  localparam logic [5:0] CFG_TOP = 6'h2E;
  localparam logic [5:0] STROBE_FIRST = 6'h30;
  localparam logic [5:0] STROBE_LAST = 6'h3D;
  localparam logic [5:0] FIFO_PORT = 6'h3F;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam logic [6:0] FIFO_FREE_CAP = 7'h0F;

  // fields inside radio_fsm_config_0
  localparam int unsigned POWER_ON_TIMEOUT_FIELD_LSB = 2;
  localparam int unsigned AUTOCAL_LSB = 4;
  localparam logic [1:0] AUTOCAL_IDLE_TO_ACTIVE = 2'h1;

  // identity values are arbitrary
  localparam logic [7:0] PART_ID_VALUE = 8'h5A;
  localparam logic [7:0] REVISION_VALUE = 8'h01;

  localparam logic [REG_COUNT-1:0][7:0] CFG_DEFAULTS = '0;

  localparam logic [2:0] STATE_IDLE = 3'h0;
  localparam logic [2:0] STATE_TX = 3'h2;
  localparam logic [2:0] STATE_FS_ON = 3'h3;
  localparam logic [2:0] STATE_CAL = 3'h4;

  typedef enum logic [5:0] {
    SECOND_PIN_OUTPUT_SELECT = 6'h01, FIRST_PIN_OUTPUT_SELECT = 6'h02,
    FIFO_THRESHOLD = 6'h03, SYNC_WORD_HIGH = 6'h04, SYNC_WORD_LOW = 6'h05,
    PACKET_LENGTH = 6'h06, PACKET_CONTROL = 6'h08, CHANNEL_NUMBER = 6'h0A,
    FREQ_WORD_HIGH = 6'h0D, FREQ_WORD_MID = 6'h0E, FREQ_WORD_LOW = 6'h0F,
    MODULATOR_CONFIG_4 = 6'h10, MODULATOR_CONFIG_3 = 6'h11, MODULATOR_CONFIG_2 = 6'h12,
    MODULATOR_CONFIG_1 = 6'h13, MODULATOR_CONFIG_0 = 6'h14, DEVIATION_SETTING = 6'h15,
    RADIO_FSM_CONFIG_1 = 6'h17, RADIO_FSM_CONFIG_0 = 6'h18, TX_FRONT_END_CONFIG = 6'h22,
    SYNTH_CAL_3 = 6'h23, SYNTH_CAL_2 = 6'h24, SYNTH_CAL_1 = 6'h25, SYNTH_CAL_0 = 6'h26,
    SYNTH_CAL_CONTROL = 6'h29, PRODUCTION_CHECK = 6'h2A, MISC_CHECK_2 = 6'h2C,
    MISC_CHECK_1 = 6'h2D, MISC_CHECK_0 = 6'h2E
  } cfg_addr_e;

  typedef enum logic [5:0] {
    PART_ID = 6'h30, CHIP_REVISION = 6'h31, RADIO_FSM_STATE = 6'h35,
    PIN_AND_PACKET_STATUS = 6'h38, PLL_CAL_SETTING = 6'h39, TX_FIFO_FILL_COUNT = 6'h3A
  } stat_addr_e;

  typedef enum logic [5:0] {
    CHIP_RESET_STROBE = 6'h30, SYNTH_ON_STROBE = 6'h31, CRYSTAL_OFF_STROBE = 6'h32,
    CALIBRATE_STROBE = 6'h33, TRANSMIT_STROBE = 6'h35, IDLE_STROBE = 6'h36,
    POWER_DOWN_STROBE = 6'h39, FIFO_FLUSH_STROBE = 6'h3B, NO_OP_STROBE = 6'h3D
  } strobe_addr_e;

  typedef enum logic [5:0] {
    MODE_SLEEP = 6'h01, MODE_XOFF = 6'h02, MODE_IDLE = 6'h04,
    MODE_CAL = 6'h08, MODE_FS_ON = 6'h10, MODE_TX = 6'h20
  } mode_e;

  typedef struct packed {
    logic rw;
    logic burst;
    logic [5:0] addr;
  } header_s;

  typedef struct packed {
    logic chip_rdy_n;
    logic [2:0] state;
    logic [3:0] fifo_free;
  } chip_status_s;

  typedef struct packed {
    logic chip_reset;
    logic synth_on;
    logic crystal_off;
    logic calibrate;
    logic transmit;
    logic idle;
    logic power_down;
    logic fifo_flush;
  } strobe_s;

endpackage : radio_spi_pkg

//--- rtl/radio_spi_regs.sv
// radio SPI slave: configuration registers, status registers and command strobes
`timescale 1ns/1ps
`default_nettype none

module radio_spi_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cal_done,
  input wire logic [6:0] tx_fifo_count,
  input wire logic tx_underflow,
  input wire logic [7:0] pin_status,
  input wire logic [7:0] pll_cal_value,
  output logic miso,
  output logic miso_oe_n,
  output logic [radio_spi_pkg::REG_COUNT-1:0][7:0] cfg_regs,
  output var radio_spi_pkg::strobe_s strobes,
  output var radio_spi_pkg::mode_e radio_mode,
  output logic fifo_wr,
  output logic [7:0] fifo_data,
  output logic power_down_armed
);

  typedef struct packed {
    logic sclk_d;
    logic cs_d;
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic [7:0] tx_sh;
    logic in_data;
    radio_spi_pkg::header_s hdr;
    logic pwd_armed;
    radio_spi_pkg::mode_e mode;
    radio_spi_pkg::mode_e cal_ret;
    logic [radio_spi_pkg::REG_COUNT-1:0][7:0] regs;
    radio_spi_pkg::strobe_s strobes;
    logic fifo_wr;
    logic [7:0] fifo_data;
  } state_s;

  localparam state_s RESET_ST = '{
    cs_d: 1'b1,
    mode: radio_spi_pkg::MODE_IDLE,
    cal_ret: radio_spi_pkg::MODE_IDLE,
    regs: radio_spi_pkg::CFG_DEFAULTS,
    default: '0
  };

  state_s s_r;
  state_s s_nxt;

  function automatic logic is_cfg(input logic [5:0] a);
    case (a)
      radio_spi_pkg::SECOND_PIN_OUTPUT_SELECT, radio_spi_pkg::FIRST_PIN_OUTPUT_SELECT,
      radio_spi_pkg::FIFO_THRESHOLD, radio_spi_pkg::SYNC_WORD_HIGH,
      radio_spi_pkg::SYNC_WORD_LOW, radio_spi_pkg::PACKET_LENGTH,
      radio_spi_pkg::PACKET_CONTROL, radio_spi_pkg::CHANNEL_NUMBER,
      radio_spi_pkg::FREQ_WORD_HIGH, radio_spi_pkg::FREQ_WORD_MID,
      radio_spi_pkg::FREQ_WORD_LOW, radio_spi_pkg::MODULATOR_CONFIG_4,
      radio_spi_pkg::MODULATOR_CONFIG_3, radio_spi_pkg::MODULATOR_CONFIG_2,
      radio_spi_pkg::MODULATOR_CONFIG_1, radio_spi_pkg::MODULATOR_CONFIG_0,
      radio_spi_pkg::DEVIATION_SETTING, radio_spi_pkg::RADIO_FSM_CONFIG_1,
      radio_spi_pkg::RADIO_FSM_CONFIG_0, radio_spi_pkg::TX_FRONT_END_CONFIG,
      radio_spi_pkg::SYNTH_CAL_3, radio_spi_pkg::SYNTH_CAL_2,
      radio_spi_pkg::SYNTH_CAL_1, radio_spi_pkg::SYNTH_CAL_0,
      radio_spi_pkg::SYNTH_CAL_CONTROL, radio_spi_pkg::PRODUCTION_CHECK,
      radio_spi_pkg::MISC_CHECK_2, radio_spi_pkg::MISC_CHECK_1,
      radio_spi_pkg::MISC_CHECK_0: is_cfg = 1'b1;
      default: is_cfg = 1'b0;
    endcase
  endfunction : is_cfg

  function automatic logic is_strobe(input radio_spi_pkg::header_s h);
    is_strobe = (h.addr >= radio_spi_pkg::STROBE_FIRST) &&
                (h.addr <= radio_spi_pkg::STROBE_LAST) && !(h.rw && h.burst);
  endfunction : is_strobe

  function automatic logic [2:0] mode_code(input radio_spi_pkg::mode_e m);
    mode_code = radio_spi_pkg::STATE_IDLE;
    unique case (m)
      radio_spi_pkg::MODE_SLEEP, radio_spi_pkg::MODE_XOFF,
      radio_spi_pkg::MODE_IDLE: mode_code = radio_spi_pkg::STATE_IDLE;
      radio_spi_pkg::MODE_CAL: mode_code = radio_spi_pkg::STATE_CAL;
      radio_spi_pkg::MODE_FS_ON: mode_code = radio_spi_pkg::STATE_FS_ON;
      radio_spi_pkg::MODE_TX: mode_code = radio_spi_pkg::STATE_TX;
    endcase
  endfunction : mode_code

  function automatic logic [7:0] status_byte(input radio_spi_pkg::mode_e m,
                                             input logic [6:0] cnt);
    radio_spi_pkg::chip_status_s st;
    logic [6:0] free;
    free = (cnt >= radio_spi_pkg::FIFO_DEPTH) ? 7'h00 : 7'(radio_spi_pkg::FIFO_DEPTH - cnt);
    st.chip_rdy_n = (m == radio_spi_pkg::MODE_SLEEP) || (m == radio_spi_pkg::MODE_XOFF);
    st.state = mode_code(m);
    st.fifo_free = (free > radio_spi_pkg::FIFO_FREE_CAP) ? 4'hF : free[3:0];
    status_byte = st;
  endfunction : status_byte

  function automatic logic [7:0] read_value(input radio_spi_pkg::header_s h,
      input logic [radio_spi_pkg::REG_COUNT-1:0][7:0] regs, input radio_spi_pkg::mode_e m,
      input logic [6:0] cnt, input logic unf, input logic [7:0] pins,
      input logic [7:0] pll);
    read_value = 8'h00;
    if (h.addr <= radio_spi_pkg::CFG_TOP && is_cfg(h.addr)) begin
      read_value = regs[h.addr];
    end else if (h.burst && h.addr >= radio_spi_pkg::STROBE_FIRST) begin
      case (h.addr)
        radio_spi_pkg::PART_ID: read_value = radio_spi_pkg::PART_ID_VALUE;
        radio_spi_pkg::CHIP_REVISION: read_value = radio_spi_pkg::REVISION_VALUE;
        radio_spi_pkg::RADIO_FSM_STATE: read_value = {5'h00, mode_code(m)};
        radio_spi_pkg::PIN_AND_PACKET_STATUS: read_value = pins;
        radio_spi_pkg::PLL_CAL_SETTING: read_value = pll;
        radio_spi_pkg::TX_FIFO_FILL_COUNT: read_value = {unf, cnt};
        default: read_value = 8'h00;
      endcase
    end
  endfunction : read_value
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] status_now;
  logic [1:0] autocal;
  radio_spi_pkg::header_s hdr_in;
  assign sclk_rise = sclk & ~s_r.sclk_d;
  assign sclk_fall = ~sclk & s_r.sclk_d;
  assign byte_done = ce & ~chip_select_n & ~s_r.cs_d & sclk_rise & (s_r.bit_cnt == 3'h7);
  assign rx_byte = {s_r.rx_sh, mosi};
  assign hdr_in = radio_spi_pkg::header_s'(rx_byte);
  assign status_now = status_byte(s_r.mode, tx_fifo_count);
  assign autocal = s_r.regs[radio_spi_pkg::RADIO_FSM_CONFIG_0][radio_spi_pkg::AUTOCAL_LSB +: 2];
  always_comb begin
    s_nxt = s_r;
    s_nxt.strobes = '0;
    s_nxt.fifo_wr = 1'b0;
    s_nxt.sclk_d = sclk;
    s_nxt.cs_d = chip_select_n;
    // cal_done returns calibration to cal_ret; strobes and sleep entry can also end it
    if (s_r.mode == radio_spi_pkg::MODE_CAL && cal_done) begin
      s_nxt.mode = s_r.cal_ret;
    end
    if (chip_select_n) begin
      s_nxt.bit_cnt = 3'h0;
      s_nxt.in_data = 1'b0;
      if (!s_r.cs_d && s_r.pwd_armed) begin
        s_nxt.pwd_armed = 1'b0;
        s_nxt.mode = radio_spi_pkg::MODE_SLEEP;
        s_nxt.regs = radio_spi_pkg::CFG_DEFAULTS;
        s_nxt.regs[radio_spi_pkg::RADIO_FSM_CONFIG_0][radio_spi_pkg::POWER_ON_TIMEOUT_FIELD_LSB +: 2] =
          s_r.regs[radio_spi_pkg::RADIO_FSM_CONFIG_0][radio_spi_pkg::POWER_ON_TIMEOUT_FIELD_LSB +: 2];
      end
    end else if (s_r.cs_d) begin
      s_nxt.tx_sh = status_now;
      s_nxt.bit_cnt = 3'h0;
      s_nxt.in_data = 1'b0;
      if (s_r.mode == radio_spi_pkg::MODE_SLEEP || s_r.mode == radio_spi_pkg::MODE_XOFF) begin
        s_nxt.mode = radio_spi_pkg::MODE_IDLE;
      end
    end else begin
      // no shift right after a load, so the msb is seen first
      if (sclk_fall && s_r.bit_cnt != 3'h0) begin
        s_nxt.tx_sh = {s_r.tx_sh[6:0], 1'b0};
      end
      if (sclk_rise) begin
        s_nxt.rx_sh = rx_byte[6:0];
        s_nxt.bit_cnt = 3'(s_r.bit_cnt + 3'h1);
      end
      if (sclk_rise && s_r.bit_cnt == 3'h7 && !s_r.in_data) begin
        s_nxt.hdr = hdr_in;
        if (is_strobe(hdr_in)) begin
          s_nxt.tx_sh = status_now;
          case (hdr_in.addr)
            radio_spi_pkg::CHIP_RESET_STROBE: begin
              s_nxt.strobes.chip_reset = 1'b1;
              s_nxt.regs = radio_spi_pkg::CFG_DEFAULTS;
              s_nxt.mode = radio_spi_pkg::MODE_IDLE;
              s_nxt.pwd_armed = 1'b0;
            end
            radio_spi_pkg::SYNTH_ON_STROBE: begin
              s_nxt.strobes.synth_on = 1'b1;
              s_nxt.cal_ret = radio_spi_pkg::MODE_FS_ON;
              s_nxt.mode = (s_r.mode == radio_spi_pkg::MODE_IDLE &&
                            autocal == radio_spi_pkg::AUTOCAL_IDLE_TO_ACTIVE) ?
                           radio_spi_pkg::MODE_CAL : radio_spi_pkg::MODE_FS_ON;
            end
            radio_spi_pkg::CRYSTAL_OFF_STROBE: begin
              s_nxt.strobes.crystal_off = 1'b1;
              s_nxt.mode = radio_spi_pkg::MODE_XOFF;
            end
            radio_spi_pkg::CALIBRATE_STROBE: begin
              s_nxt.strobes.calibrate = 1'b1;
              if (s_r.mode == radio_spi_pkg::MODE_IDLE) begin
                s_nxt.mode = radio_spi_pkg::MODE_CAL;
                s_nxt.cal_ret = radio_spi_pkg::MODE_IDLE;
              end
            end
            radio_spi_pkg::TRANSMIT_STROBE: begin
              s_nxt.strobes.transmit = 1'b1;
              s_nxt.cal_ret = radio_spi_pkg::MODE_TX;
              s_nxt.mode = (s_r.mode == radio_spi_pkg::MODE_IDLE &&
                            autocal == radio_spi_pkg::AUTOCAL_IDLE_TO_ACTIVE) ?
                           radio_spi_pkg::MODE_CAL : radio_spi_pkg::MODE_TX;
            end
            radio_spi_pkg::IDLE_STROBE: begin
              s_nxt.strobes.idle = 1'b1;
              s_nxt.mode = radio_spi_pkg::MODE_IDLE;
            end
            radio_spi_pkg::POWER_DOWN_STROBE: begin
              s_nxt.strobes.power_down = 1'b1;
              s_nxt.pwd_armed = 1'b1;
            end
            radio_spi_pkg::FIFO_FLUSH_STROBE: s_nxt.strobes.fifo_flush = 1'b1;
            default: s_nxt.strobes = '0;
          endcase
        end else begin
          s_nxt.in_data = 1'b1;
          s_nxt.tx_sh = hdr_in.rw ? read_value(hdr_in, s_r.regs, s_r.mode, tx_fifo_count,
                                               tx_underflow, pin_status, pll_cal_value)
                                  : status_now;
        end
      end else if (sclk_rise && s_r.bit_cnt == 3'h7) begin
        s_nxt.tx_sh = status_now;
        if (!s_r.hdr.rw) begin
          if (s_r.hdr.addr == radio_spi_pkg::FIFO_PORT) begin
            s_nxt.fifo_wr = 1'b1;
            s_nxt.fifo_data = rx_byte;
          end else if (s_r.hdr.addr <= radio_spi_pkg::CFG_TOP && is_cfg(s_r.hdr.addr)) begin
            s_nxt.regs[s_r.hdr.addr] = rx_byte;
          end
        end
        if (s_r.hdr.burst) begin
          if (s_r.hdr.addr != radio_spi_pkg::FIFO_PORT) begin
            s_nxt.hdr.addr = 6'(s_r.hdr.addr + 6'h01);
          end
          if (s_r.hdr.rw) begin
            s_nxt.tx_sh = read_value(s_nxt.hdr, s_r.regs, s_r.mode, tx_fifo_count,
                                     tx_underflow, pin_status, pll_cal_value);
          end
        end else begin
          s_nxt.in_data = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= RESET_ST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
  assign miso = s_r.tx_sh[7];
  assign miso_oe_n = chip_select_n;
  assign cfg_regs = s_r.regs;
  assign strobes = s_r.strobes;
  assign radio_mode = s_r.mode;
  assign fifo_wr = s_r.fifo_wr;
  assign fifo_data = s_r.fifo_data;
  assign power_down_armed = s_r.pwd_armed;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic hdr_strobe;
  logic data_done;
  assign hdr_strobe = byte_done & ~s_r.in_data & is_strobe(hdr_in);
  assign data_done = byte_done & s_r.in_data;
  sequence s_pulse_one(logic sig);
    sig ##1 !sig;
  endsequence
  property p_status_on_header;
    (ce && !chip_select_n && s_r.cs_d) |=> (miso == $past(status_now[7]));
  endproperty
  a_status_on_header: assert property (p_status_on_header)
    else $error("status byte not driven at access start");
  property p_reset_strobe;
    (hdr_strobe && hdr_in.addr == radio_spi_pkg::CHIP_RESET_STROBE) |=>
      (s_r.regs == radio_spi_pkg::CFG_DEFAULTS && s_r.mode == radio_spi_pkg::MODE_IDLE);
  endproperty
  a_reset_strobe: assert property (p_reset_strobe)
    else $error("reset strobe left registers off default");
  property p_strobe_no_store;
    (hdr_strobe && hdr_in.addr != radio_spi_pkg::CHIP_RESET_STROBE) |=>
      (s_r.regs == $past(s_r.regs) && !s_r.in_data);
  endproperty
  a_strobe_no_store: assert property (p_strobe_no_store)
    else $error("strobe altered register contents");
  property p_status_read;
    (byte_done && !s_r.in_data && hdr_in.rw && hdr_in.burst &&
     hdr_in.addr == radio_spi_pkg::RADIO_FSM_STATE) |=>
      (s_r.tx_sh == {5'h00, mode_code($past(s_r.mode))});
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("state register read wrong");
  property p_fifo_write;
    (data_done && !s_r.hdr.rw && s_r.hdr.addr == radio_spi_pkg::FIFO_PORT) |=>
      (s_pulse_one(fifo_wr) and (fifo_data == $past(rx_byte)));
  endproperty
  a_fifo_write: assert property (p_fifo_write)
    else $error("fifo write not one pulse with byte");
  property p_cfg_write;
    (data_done && !s_r.hdr.rw && is_cfg(s_r.hdr.addr)) |=>
      (s_r.regs[$past(s_r.hdr.addr)] == $past(rx_byte));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write lost");
  property p_holes_zero;
    s_r.regs[6'h00] == 8'h00 && s_r.regs[6'h07] == 8'h00 &&
    s_r.regs[6'h16] == 8'h00 && s_r.regs[6'h2B] == 8'h00;
  endproperty
  a_holes_zero: assert property (p_holes_zero)
    else $error("unbuilt location holds data");
  property p_burst_step;
    (data_done && s_r.hdr.burst && s_r.hdr.addr < radio_spi_pkg::CFG_TOP) |=>
      (s_r.hdr.addr == 6'($past(s_r.hdr.addr) + 6'h01) && s_r.in_data);
  endproperty
  a_burst_step: assert property (p_burst_step)
    else $error("burst address did not advance");
  sequence s_armed_awake;
    s_r.pwd_armed && s_r.mode != radio_spi_pkg::MODE_SLEEP;
  endsequence
  property p_power_down;
    (hdr_strobe && hdr_in.addr == radio_spi_pkg::POWER_DOWN_STROBE) |=> s_armed_awake;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("power down not armed or entered early");
  property p_sleep_entry;
    (ce && chip_select_n && !s_r.cs_d && s_r.pwd_armed) |=>
      (s_r.mode == radio_spi_pkg::MODE_SLEEP &&
       s_r.regs[radio_spi_pkg::RADIO_FSM_CONFIG_0] ==
       ($past(s_r.regs[radio_spi_pkg::RADIO_FSM_CONFIG_0]) & 8'h0C));
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry kept wrong fields");
  property p_tx_autocal;
    (hdr_strobe && hdr_in.addr == radio_spi_pkg::TRANSMIT_STROBE &&
     s_r.mode == radio_spi_pkg::MODE_IDLE && autocal == radio_spi_pkg::AUTOCAL_IDLE_TO_ACTIVE)
      |=> (s_r.mode == radio_spi_pkg::MODE_CAL && s_r.cal_ret == radio_spi_pkg::MODE_TX);
  endproperty
  a_tx_autocal: assert property (p_tx_autocal)
    else $error("transmit skipped calibration");
  property p_idle_strobe;
    (hdr_strobe && hdr_in.addr == radio_spi_pkg::IDLE_STROBE) |=>
      (s_r.mode == radio_spi_pkg::MODE_IDLE) and s_pulse_one(s_r.strobes.idle);
  endproperty
  a_idle_strobe: assert property (p_idle_strobe)
    else $error("idle strobe did not stop radio");
  property p_flush;
    (hdr_strobe && hdr_in.addr == radio_spi_pkg::FIFO_FLUSH_STROBE) |=>
      s_pulse_one(strobes.fifo_flush);
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush pulse missing");
endmodule : radio_spi_regs

`default_nettype wire

//--- verification/spi_host_model.sv
// host model: SPI master framing accesses to the radio port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clock,
  input wire logic miso,
  output logic chip_select_n,
  output logic sclk,
  output logic mosi
);
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic open_access();
    chip_select_n = 1'b0;
    tick(2);
  endtask : open_access
  task automatic close_access();
    sclk = 1'b0;
    tick(2);
    chip_select_n = 1'b1;
    // released line must not look like stale data
    mosi = ~mosi;
    tick(3);
  endtask : close_access
  // mode 0, msb first; two cycles per phase so the sampler sees each level
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      tick(2);
      rx[i] = miso;
      sclk = 1'b1;
      tick(2);
    end
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

//--- verification/tb.sv
// testbench: registers, status reads and strobes through the SPI port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, rst_n, ce, cal_done, tx_underflow, miso, miso_oe_n, fifo_wr, power_down_armed;
  logic chip_select_n, sclk, mosi;
  logic [6:0] tx_fifo_count;
  logic [7:0] pin_status, pll_cal_value, fifo_data, st, rx;
  logic [radio_spi_pkg::REG_COUNT-1:0][7:0] cfg_regs;
  radio_spi_pkg::strobe_s strobes;
  radio_spi_pkg::mode_e radio_mode;
  logic [5:0] adr [5] = '{6'h01, 6'h0a, 6'h17, 6'h22, 6'h2e};
  int err_count = 0, n_checks = 0, cycles = 0, wr_cnt = 0;
  int pulse_cnt [8] = '{default: 0};
  radio_spi_regs dut (.clock(clock), .rst_n(rst_n), .ce(ce), .chip_select_n(chip_select_n),
    .sclk(sclk), .mosi(mosi), .cal_done(cal_done), .tx_fifo_count(tx_fifo_count),
    .tx_underflow(tx_underflow), .pin_status(pin_status), .pll_cal_value(pll_cal_value),
    .miso(miso), .miso_oe_n(miso_oe_n), .cfg_regs(cfg_regs), .strobes(strobes),
    .radio_mode(radio_mode), .fifo_wr(fifo_wr), .fifo_data(fifo_data),
    .power_down_armed(power_down_armed));
  spi_host_model host (.clock(clock), .miso(miso), .chip_select_n(chip_select_n),
    .sclk(sclk), .mosi(mosi));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // pulse counters; one-cycle pulses are easy to miss by polling
  always @(posedge clock) begin
    cycles++;
    if (fifo_wr === 1'b1)
      wr_cnt++;
    for (int i = 0; i < 8; i++)
      if (strobes[i] === 1'b1)
        pulse_cnt[i]++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  function automatic logic [7:0] stat(input logic [2:0] s);
    // free space saturates at 15 in the status byte
    return {1'b0, s, (tx_fifo_count < 7'h31) ? 4'hf : 4'(7'h40 - tx_fifo_count)};
  endfunction : stat
  task automatic wr(input logic [7:0] hdr, input logic [7:0] d);
    host.open_access();
    host.xfer(hdr, st);
    chk_byte(st, stat(3'h0));
    host.xfer(d, st);
    chk_byte(st, stat(3'h0));
    host.close_access();
  endtask : wr
  task automatic rd(input logic [7:0] hdr, input logic [7:0] exp);
    host.open_access();
    host.xfer(hdr, st);
    host.xfer(8'h00, rx);
    host.close_access();
    chk_byte(rx, exp);
  endtask : rd
  task automatic sb(input logic [7:0] code, input logic [2:0] s, input int b,
                    input logic [5:0] m);
    int snap [8];
    snap = pulse_cnt;
    host.open_access();
    host.xfer(code, st);
    chk_byte(st, stat(s));
    chk_byte({7'b0, power_down_armed}, {7'b0, code == 8'h39});
    chk_byte({7'b0, miso_oe_n}, 8'h00);
    host.close_access();
    for (int i = 0; i < 8; i++)
      chk_byte(8'(pulse_cnt[i] - snap[i]), {7'b0, i == b});
    chk_byte({2'b00, radio_mode}, {2'b00, m});
  endtask : sb
  task automatic cal_end(input logic [5:0] m);
    cal_done = 1'b1;
    host.tick(1);
    cal_done = 1'b0;
    host.tick(1);
    chk_byte({2'b00, radio_mode}, {2'b00, m});
  endtask : cal_end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    cal_done = 1'b0;
    tx_underflow = 1'b1;
    tx_fifo_count = 7'h3c;
    pin_status = 8'h96;
    pll_cal_value = 8'h3c;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    host.tick(2);
    chk_byte(cfg_regs[6'h18], 8'h00);
    chk_byte({2'b00, radio_mode}, 8'h04);
    chk_byte({7'b0, miso_oe_n}, 8'h01);
    foreach (adr[i]) begin
      wr({2'b00, adr[i]}, 8'h5a ^ {2'b00, adr[i]});
      rd({2'b10, adr[i]}, 8'h5a ^ {2'b00, adr[i]});
      chk_byte(cfg_regs[adr[i]], 8'h5a ^ {2'b00, adr[i]});
    end
    wr(8'h07, 8'hff);
    rd(8'h87, 8'h00);
    host.open_access();
    host.xfer(8'h43, st);
    for (int i = 0; i < 3; i++)
      host.xfer(8'ha0 + 8'(i), st);
    host.close_access();
    host.open_access();
    host.xfer(8'hc3, st);
    for (int i = 0; i < 3; i++) begin
      host.xfer(8'h00, rx);
      chk_byte(rx, 8'ha0 + 8'(i));
    end
    host.close_access();
    rd(8'hf0, radio_spi_pkg::PART_ID_VALUE);
    rd(8'hf1, radio_spi_pkg::REVISION_VALUE);
    rd(8'hf5, 8'h00);
    rd(8'hf8, pin_status);
    rd(8'hf9, pll_cal_value);
    rd(8'hfa, {tx_underflow, tx_fifo_count});
    tx_fifo_count = 7'h00;
    wr(8'h06, 8'h11);
    tx_fifo_count = 7'h3c;
    // fifo port is only ever written
    wr(8'h3f, 8'hc3);
    chk_byte(8'(wr_cnt), 8'h01);
    chk_byte(fifo_data, 8'hc3);
    sb(8'h35, 3'h0, 3, 6'h20);
    sb(8'h36, 3'h2, 2, 6'h04);
    sb(8'h31, 3'h0, 6, 6'h10);
    sb(8'h36, 3'h3, 2, 6'h04);
    sb(8'h33, 3'h0, 4, 6'h08);
    cal_end(6'h04);
    sb(8'h3b, 3'h0, 0, 6'h04);
    sb(8'h3d, 3'h0, 8, 6'h04);
    wr(8'h18, 8'h1c);
    sb(8'h35, 3'h0, 3, 6'h08);
    cal_end(6'h20);
    sb(8'h36, 3'h2, 2, 6'h04);
    sb(8'h31, 3'h0, 6, 6'h08);
    cal_end(6'h10);
    sb(8'h36, 3'h3, 2, 6'h04);
    sb(8'h33, 3'h0, 4, 6'h08);
    cal_end(6'h04);
    sb(8'h32, 3'h0, 5, 6'h02);
    rd(8'h8a, 8'h50);
    chk_byte({2'b00, radio_mode}, 8'h04);
    wr(8'h0a, 8'hab);
    sb(8'h39, 3'h0, 1, 6'h01);
    chk_byte(cfg_regs[6'h0a], 8'h00);
    chk_byte(cfg_regs[6'h18], 8'h0c);
    rd(8'h98, 8'h0c);
    wr(8'h0a, 8'h55);
    sb(8'h30, 3'h0, 7, 6'h04);
    rd(8'h8a, 8'h00);
    chk_byte(cfg_regs[6'h18], 8'h00);
    // mid-run reset must restore defaults too
    wr(8'h0a, 8'h77);
    rst_n = 1'b0;
    host.tick(1);
    rst_n = 1'b1;
    host.tick(2);
    chk_byte(cfg_regs[6'h0a], 8'h00);
    chk_byte({2'b00, radio_mode}, 8'h04);
    rd(8'h8a, 8'h00);
    complete_run();
  end
endmodule : tb
`default_nettype wire
